// ---- hdl/sarsq_top.sv ----
/*
 scan sequencer and control for a 12-bit successive-approximation converter.
 assumes the analog front end answers each bit trial on cmp_in by the next conversion tick;
 all control and status bits are plain ports, no register bus.
*/
// Functional notes
// - conversion clock never exceeds 18 MHz
// - conversion spans at least 18 conversion clocks
// - reference select among four sources
// - sample window length is programmable
// - eight channels scanned standard, sixteen when extended; firmware steps reach all sixteen
// - scan visits enabled channels autonomously
// - no idle cycles between channels
// - scan machine or firmware steps channel
// - one result holding register per channel
// - per-channel sample time applied each conversion
// - out-of-range interrupt on limit window violation
// - range check on each fresh result
// - temperature sensor selectable as input
// - no conversions in low-power states
// - sequencer drives amplifier routing switches
`timescale 1ns/10ps
module sarsq_top
   import sarsq_pkg::*;
#(
   parameter int NUM_CHAN = sarsq_pkg::CHAN_MAX,
   parameter int SW_BITS = 4
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic active_mode,
   input wire logic scan_start,
   input wire logic continuous,
   input wire logic fw_step_mode,
   input wire logic fw_step,
   input wire logic [sarsq_pkg::CHAN_IDX_BITS-1:0] fw_chan,
   input wire logic extend_16,
   input wire logic [sarsq_pkg::CHAN_MAX-1:0] chan_enable,
   input wire logic temp_sel,
   input wire logic [sarsq_pkg::DIV_BITS-1:0] conv_div,
   input wire logic [sarsq_pkg::CHAN_MAX*sarsq_pkg::SAMPLE_BITS-1:0] sample_time,
   input wire logic [sarsq_pkg::CHAN_MAX*SW_BITS-1:0] chan_switches,
   input wire sarsq_pkg::sarsq_ref_type ref_sel,
   input wire logic [sarsq_pkg::RESULT_BITS-1:0] limit_low,
   input wire logic [sarsq_pkg::RESULT_BITS-1:0] limit_high,
   input wire logic range_irq_clear,
   input wire logic cmp_in,
   input wire logic [sarsq_pkg::CHAN_IDX_BITS-1:0] read_chan,
   output logic [sarsq_pkg::RESULT_BITS-1:0] read_data,
   output logic [sarsq_pkg::CHAN_IDX_BITS-1:0] mux_chan,
   output logic mux_temp,
   output logic [1:0] ref_out,
   output logic sample_hold,
   output logic [sarsq_pkg::RESULT_BITS-1:0] dac_code,
   output logic [SW_BITS-1:0] amp_switches,
   output logic busy,
   output logic result_valid,
   output logic [sarsq_pkg::RESULT_BITS-1:0] result_data,
   output logic [sarsq_pkg::CHAN_IDX_BITS-1:0] result_chan,
   output logic range_irq,
   output logic scan_done
);
   import sarsq_pkg::*;

   if (NUM_CHAN != CHAN_MAX || SW_BITS < 1) begin
      $error("sarsq_top: NUM_CHAN must be 16 and SW_BITS at least 1");
   end

   sarsq_state_type state_reg;
   logic [CHAN_IDX_BITS-1:0] chan_reg;
   logic [SAMPLE_BITS-1:0] samp_cnt_reg;
   logic [4:0] conv_cnt_reg;
   logic [RESULT_BITS-1:0] sar_reg;
   logic [RESULT_BITS-1:0] trial_reg;
   logic [RESULT_BITS-1:0] result_mem [CHAN_MAX];
   logic [2:0] cmp_sync_reg;
   logic cmp_level_reg;
   logic [DIV_BITS-1:0] div_eff;
   logic tick;
   logic [CHAN_MAX-1:0] live_mask;
   logic [CHAN_IDX_BITS-1:0] next_chan;
   logic next_found;
   logic [CHAN_IDX_BITS-1:0] first_chan;
   logic first_found;
   logic conv_last;
   logic [RESULT_BITS-1:0] final_code;
   logic launch;

   // first enabled channel at or after a start index; used twice
   function automatic logic [CHAN_IDX_BITS:0] find_chan(input logic [CHAN_MAX-1:0] mask,
                                                        input logic [CHAN_IDX_BITS:0] from);
      logic [CHAN_IDX_BITS:0] hit;
      hit = {1'b0, {CHAN_IDX_BITS{1'b0}}};
      for (int i = CHAN_MAX - 1; i >= 0; i--) begin
         if (mask[i] && i >= int'(from)) begin
            hit = {1'b1, CHAN_IDX_BITS'(i)};
         end
      end
      return hit;
   endfunction

   function automatic logic [SAMPLE_BITS-1:0] samp_of(input logic [CHAN_IDX_BITS-1:0] ch,
                                                     input logic [CHAN_MAX*SAMPLE_BITS-1:0] tbl);
      return tbl[ch*SAMPLE_BITS +: SAMPLE_BITS];
   endfunction

   // upper eight channels are scanned only in the extended configuration; firmware steps take fw_chan unmasked
   assign live_mask = extend_16 ? chan_enable : {{(CHAN_MAX-CHAN_STD){1'b0}}, chan_enable[CHAN_STD-1:0]};
   // clamp so the conversion clock stays at or below its ceiling
   assign div_eff = (conv_div < DIV_BITS'(CONV_DIV_MIN)) ? DIV_BITS'(CONV_DIV_MIN) : conv_div;

   sarsq_tick #(
      .DIV_BITS(DIV_BITS)
   ) u_tick (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .run(state_reg != SARSQ_IDLE),
      .div_val(div_eff),
      .tick(tick)
   );

   // skipping happens in one combinational search, so disabled channels cost no cycles
   always_comb begin
      logic [CHAN_IDX_BITS:0] n;
      logic [CHAN_IDX_BITS:0] f;
      n = find_chan(live_mask, {1'b0, chan_reg} + 1'b1);
      f = find_chan(live_mask, '0);
      next_chan = n[CHAN_IDX_BITS-1:0];
      next_found = n[CHAN_IDX_BITS];
      first_chan = f[CHAN_IDX_BITS-1:0];
      first_found = f[CHAN_IDX_BITS];
   end

   // comparator answer crosses from the analog side
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cmp_sync_reg <= 3'h0;
         cmp_level_reg <= 1'b0;
      end else if (clk_en) begin
         cmp_sync_reg <= {cmp_sync_reg[1:0], cmp_in};
         if (cmp_sync_reg[2] == cmp_sync_reg[1]) begin
            cmp_level_reg <= cmp_sync_reg[2];
         end
      end
   end

   // 12 bit trials plus settle cycles give 18 ticks in all
   assign conv_last = tick && conv_cnt_reg == 5'(CONV_CYCLES_MIN - 1);
   assign final_code = sar_reg;
   assign launch = active_mode && (fw_step_mode ? fw_step : scan_start);

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_reg <= SARSQ_IDLE;
         chan_reg <= '0;
         samp_cnt_reg <= '0;
         conv_cnt_reg <= '0;
         busy <= 1'b0;
         scan_done <= 1'b0;
      end else if (clk_en) begin
         scan_done <= 1'b0;
         if (!active_mode) begin
            // high-speed clock is gone outside active modes: abandon any conversion
            state_reg <= SARSQ_IDLE;
            busy <= 1'b0;
         end else begin
            unique case (state_reg)
               SARSQ_IDLE: begin
                  if (launch && (fw_step_mode || first_found)) begin
                     chan_reg <= fw_step_mode ? fw_chan : first_chan;
                     state_reg <= SARSQ_SAMPLE;
                     samp_cnt_reg <= '0;
                     busy <= 1'b1;
                  end
               end
               SARSQ_SAMPLE: begin
                  if (tick) begin
                     if (samp_cnt_reg + 1'b1 >= samp_of(chan_reg, sample_time)) begin
                        state_reg <= SARSQ_CONVERT;
                        conv_cnt_reg <= '0;
                     end else begin
                        samp_cnt_reg <= samp_cnt_reg + 1'b1;
                     end
                  end
               end
               SARSQ_CONVERT: begin
                  if (tick) begin
                     conv_cnt_reg <= conv_cnt_reg + 1'b1;
                  end
                  if (conv_last) begin
                     // next channel goes straight into sampling, no gap tick
                     if (!fw_step_mode && next_found) begin
                        chan_reg <= next_chan;
                        state_reg <= SARSQ_SAMPLE;
                        samp_cnt_reg <= '0;
                     end else if (!fw_step_mode && continuous && first_found) begin
                        chan_reg <= first_chan;
                        state_reg <= SARSQ_SAMPLE;
                        samp_cnt_reg <= '0;
                        scan_done <= 1'b1;
                     end else begin
                        state_reg <= SARSQ_IDLE;
                        busy <= 1'b0;
                        scan_done <= !fw_step_mode;
                     end
                  end
               end
               default: begin
                  state_reg <= SARSQ_IDLE;
                  busy <= 1'b0;
               end
            endcase
         end
      end
   end

   // successive approximation: bit trials on ticks 2..13, rest is settle and transfer
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         sar_reg <= '0;
         trial_reg <= '0;
      end else if (clk_en) begin
         if (state_reg != SARSQ_CONVERT) begin
            sar_reg <= '0;
            trial_reg <= {1'b1, {(RESULT_BITS-1){1'b0}}};
         end else if (tick && conv_cnt_reg >= 5'd1 && conv_cnt_reg <= 5'(RESULT_BITS)) begin
            if (conv_cnt_reg == 5'd1) begin
               sar_reg <= trial_reg;
            end else begin
               sar_reg <= (cmp_level_reg ? sar_reg : (sar_reg & ~(trial_reg << 1))) | trial_reg;
            end
            trial_reg <= trial_reg >> 1;
         end else if (tick && conv_cnt_reg == 5'(RESULT_BITS + 1)) begin
            // trial register is already empty here, so the last bit is cleared by position
            if (!cmp_level_reg) begin
               sar_reg <= {sar_reg[RESULT_BITS-1:1], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         result_valid <= 1'b0;
         result_data <= '0;
         result_chan <= '0;
      end else if (clk_en) begin
         result_valid <= conv_last && active_mode;
         if (conv_last) begin
            result_data <= final_code;
            result_chan <= chan_reg;
         end
      end
   end

   // results kept per channel so software may collect them late
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         for (int i = 0; i < CHAN_MAX; i++) begin
            result_mem[i] <= '0;
         end
         read_data <= '0;
      end else if (clk_en) begin
         if (conv_last && active_mode) begin
            result_mem[chan_reg] <= final_code;
         end
         read_data <= result_mem[read_chan];
      end
   end

   // checked on the fresh code, not on the buffer; a set beats a same-cycle clear
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         range_irq <= 1'b0;
      end else if (clk_en) begin
         if (conv_last && active_mode && (final_code < limit_low || final_code > limit_high)) begin
            range_irq <= 1'b1;
         end else if (range_irq_clear) begin
            range_irq <= 1'b0;
         end
      end
   end

   // analog front end steering follows the channel being sampled
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         mux_chan <= '0;
         mux_temp <= 1'b0;
         ref_out <= SARSQ_REF_SUPPLY;
         sample_hold <= 1'b0;
         dac_code <= '0;
         amp_switches <= '0;
      end else if (clk_en) begin
         mux_chan <= chan_reg;
         mux_temp <= temp_sel;
         ref_out <= ref_sel;
         sample_hold <= state_reg == SARSQ_SAMPLE && active_mode;
         dac_code <= sar_reg;
         amp_switches <= state_reg == SARSQ_IDLE ? '0 : chan_switches[chan_reg*SW_BITS +: SW_BITS];
      end
   end
endmodule

// ---- hdl/sarsq_pkg.sv ----
/*
 package for the sar converter scan sequencer: timing counts, widths, encodings.
 assumes a 10 MHz system clock; the converter clock is derived by the sequencer itself.
*/
package sarsq_pkg;
   localparam int SYS_CLK_HZ = 10000000;
   localparam int CONV_CLK_MAX_HZ = 18000000;
   // the conversion clock may not exceed this, so divider never goes below this
   localparam int CONV_DIV_MIN = (SYS_CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;
   localparam int CONV_CYCLES_MIN = 18;
   localparam int RESULT_BITS = 12;
   localparam int CHAN_STD = 8;
   localparam int CHAN_MAX = 16;
   localparam int CHAN_IDX_BITS = 4;
   localparam int SAMPLE_BITS = 8;
   localparam int DIV_BITS = 8;
   localparam logic [DIV_BITS-1:0] DIV_RESET = 8'h01;
   localparam logic [SAMPLE_BITS-1:0] SAMPLE_RESET = 8'h03;
   localparam logic [RESULT_BITS-1:0] LIMIT_LOW_RESET = 12'h000;
   localparam logic [RESULT_BITS-1:0] LIMIT_HIGH_RESET = 12'hFFF;
   typedef enum logic [1:0] {
      SARSQ_REF_SUPPLY = 2'b00,
      SARSQ_REF_HALF_SUPPLY = 2'b01,
      SARSQ_REF_BANDGAP = 2'b10,
      SARSQ_REF_EXTERNAL = 2'b11
   } sarsq_ref_type;
   typedef enum logic [1:0] {
      SARSQ_IDLE = 2'b00,
      SARSQ_SAMPLE = 2'b01,
      SARSQ_CONVERT = 2'b10
   } sarsq_state_type;
endpackage

// ---- hdl/sarsq_tick.sv ----
/*
 conversion clock tick generator: one-cycle tick every div_val enabled system clocks.
 assumes div_val is at least one; a zero is served as one.
*/
`timescale 1ns/10ps
module sarsq_tick #(
   parameter int DIV_BITS = 8
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic run,
   input wire logic [DIV_BITS-1:0] div_val,
   output logic tick
);
   logic [DIV_BITS-1:0] cnt_reg;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else if (clk_en) begin
         // restart phase when idle so every scan starts on the same grid
         if (!run || cnt_reg + 1'b1 >= div_val) begin
            cnt_reg <= '0;
            tick <= run;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick <= 1'b0;
         end
      end
   end
endmodule

// ---- dv/sarsq_chk_assertions.sv ----
/*
 port checker for the scan sequencer top.
 assumes one clock domain and limits, extend_16 and modes held steady during a scan.
*/
`timescale 1ns/10ps
module sarsq_chk
   import sarsq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic active_mode,
   input wire logic fw_step_mode,
   input wire logic extend_16,
   input wire logic [sarsq_pkg::CHAN_MAX-1:0] chan_enable,
   input wire logic [sarsq_pkg::DIV_BITS-1:0] conv_div,
   input wire sarsq_pkg::sarsq_ref_type ref_sel,
   input wire logic [sarsq_pkg::RESULT_BITS-1:0] limit_low,
   input wire logic [sarsq_pkg::RESULT_BITS-1:0] limit_high,
   input wire logic range_irq_clear,
   input wire logic [sarsq_pkg::CHAN_IDX_BITS-1:0] mux_chan,
   input wire logic [1:0] ref_out,
   input wire logic sample_hold,
   input wire logic busy,
   input wire logic result_valid,
   input wire logic [sarsq_pkg::RESULT_BITS-1:0] result_data,
   input wire logic range_irq,
   input wire logic scan_done
);
   logic [15:0] low_cnt_reg;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // counts past a frozen clk_en too, so the bound only gets looser
   always_ff @(posedge sys_clk) begin
      if (!rstn || sample_hold) begin
         low_cnt_reg <= 16'h0000;
      end else if (low_cnt_reg != 16'hFFFF) begin
         low_cnt_reg <= low_cnt_reg + 16'h0001;
      end
   end
   sequence s_bad_result;
      result_valid && (result_data < limit_low || result_data > limit_high);
   endsequence
   sequence s_sleep;
      !active_mode && clk_en;
   endsequence
   AST_VALID_ONE: assert property (result_valid |=> !result_valid) else $error("result pulse too long");
   AST_DONE_ONE: assert property (scan_done |=> !scan_done) else $error("done pulse too long");
   AST_DONE_SCAN: assert property (scan_done |-> !fw_step_mode) else $error("done in firmware mode");
   AST_SLEEP: assert property (s_sleep |=> !busy) else $error("busy while not active");
   AST_MASK16: assert property (busy && sample_hold && !extend_16 && !fw_step_mode |-> !mux_chan[3])
      else $error("upper channel sampled");
   AST_SKIP: assert property (busy && sample_hold && !fw_step_mode |-> chan_enable[mux_chan])
      else $error("disabled channel sampled");
   AST_REF: assert property ($past(clk_en) && $past(rstn) |-> ref_out == $past(ref_sel))
      else $error("reference select wrong");
   AST_CONV_LEN: assert property (result_valid |->
      low_cnt_reg >= 16'(CONV_CYCLES_MIN - 1) * {8'h00, conv_div}) else $error("conversion too short");
   AST_RANGE: assert property (s_bad_result |-> ##[0:1] range_irq) else $error("range flag missed");
   AST_IRQ_HOLD: assert property (range_irq && !range_irq_clear |=> range_irq) else $error("range flag lost");
endmodule

bind sarsq_top sarsq_chk u_chk (.sys_clk, .rstn, .clk_en, .active_mode, .fw_step_mode, .extend_16, .chan_enable,
   .conv_div, .ref_sel, .limit_low, .limit_high, .range_irq_clear, .mux_chan, .ref_out, .sample_hold, .busy,
   .result_valid, .result_data, .range_irq, .scan_done);

// ---- dv/sarsq_afe_model.sv ----
/*
 behavioural analog front end: a fixed level per channel, answers dac trials.
 assumes sampling while sample_hold is high and trials on dac_code afterwards.
*/
`timescale 1ns/10ps
module sarsq_afe_model
   import sarsq_pkg::*;
#(
   parameter logic [RESULT_BITS-1:0] TEMP_LEVEL = 12'hABC
) (
   input wire logic sys_clk,
   input wire logic [sarsq_pkg::CHAN_IDX_BITS-1:0] mux_chan,
   input wire logic mux_temp,
   input wire logic sample_hold,
   input wire logic [sarsq_pkg::RESULT_BITS-1:0] dac_code,
   output logic cmp_in
);
   logic [RESULT_BITS-1:0] held_reg = 12'h000;
   logic cmp_reg = 1'b0;
   assign cmp_in = cmp_reg;
   // level is captured only inside the window, like a real hold capacitor
   always @(posedge sys_clk) begin
      if (sample_hold) begin
         held_reg <= mux_temp ? TEMP_LEVEL : {mux_chan, 8'h5A};
      end
      cmp_reg <= (dac_code <= held_reg);
   end
endmodule

// ---- dv/tb_top.sv ----
/*
 self-checking bench for the scan sequencer: scans, firmware steps, range flag, sleep.
 assumes the front end model beside it and a 10 MHz clock.
*/
`timescale 1ns/10ps
module tb_top;
   import sarsq_pkg::*;
   logic sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, active_mode = 1'b1, continuous = 1'b0;
   logic scan_start = 1'b0, fw_step_mode = 1'b0, fw_step = 1'b0, extend_16 = 1'b0, temp_sel = 1'b0;
   logic [3:0] fw_chan = 4'h0, read_chan = 4'h0;
   logic [15:0] chan_enable = 16'h8025;
   logic [7:0] conv_div = 8'h08;
   logic [127:0] sample_time;
   logic [63:0] chan_switches;
   sarsq_ref_type ref_sel = SARSQ_REF_SUPPLY;
   logic [11:0] limit_low = 12'h010, limit_high = 12'h400;
   logic range_irq_clear = 1'b0;
   logic cmp_in, mux_temp, sample_hold, busy, result_valid, range_irq, scan_done;
   logic [11:0] read_data, dac_code, result_data;
   logic [3:0] mux_chan, result_chan, amp_switches;
   logic [1:0] ref_out;
   int num_errors = 0, samples_checked = 0, cyc = 0, last_cyc = 0, done_cnt = 0;
   int exp_ch[$], exp_dat[$], exp_gap[$];
   int rc[3] = '{0, 2, 5};
   sarsq_top #(.NUM_CHAN(16), .SW_BITS(4)) dut (.sys_clk, .rstn, .clk_en, .active_mode, .scan_start, .continuous,
      .fw_step_mode, .fw_step, .fw_chan, .extend_16, .chan_enable, .temp_sel, .conv_div, .sample_time,
      .chan_switches, .ref_sel, .limit_low, .limit_high, .range_irq_clear, .cmp_in, .read_chan, .read_data,
      .mux_chan, .mux_temp, .ref_out, .sample_hold, .dac_code, .amp_switches, .busy, .result_valid,
      .result_data, .result_chan, .range_irq, .scan_done);
   sarsq_afe_model afe (.sys_clk, .mux_chan, .mux_temp, .sample_hold, .dac_code, .cmp_in);
   always #50 sys_clk = ~sys_clk;
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // generous ceiling: the whole run needs a few thousand cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   always @(negedge sys_clk) begin
      if (scan_done === 1'b1) done_cnt++;
      if (sample_hold === 1'b1 && fw_step_mode === 1'b0)
         chk("switches", {12'h000, chan_switches[4*mux_chan+:4]}, {12'h000, amp_switches});
      if (result_valid === 1'b1) begin
         if (exp_ch.size() == 0) begin
            chk("spare result", 16'h0000, 16'h0001);
         end else begin
            if (exp_ch[0] >= 0) chk("result channel", 16'(exp_ch[0]), {12'h000, result_chan});
            chk("result data", 16'(exp_dat[0]), {4'h0, result_data});
            if (exp_gap[0] > 0) chk("result spacing", 16'(exp_gap[0]), 16'(cyc - last_cyc));
            void'(exp_ch.pop_front());
            void'(exp_dat.pop_front());
            void'(exp_gap.pop_front());
         end
         last_cyc = cyc;
      end
   end
   task automatic expect_res(input int ch, input int dat, input int gap);
      exp_ch.push_back(ch);
      exp_dat.push_back(dat);
      exp_gap.push_back(gap);
   endtask
   // bounded wait until all expected results are in and busy is low
   task automatic wait_done();
      int n;
      n = 0;
      @(negedge sys_clk);
      while ((exp_ch.size() != 0 || busy !== 1'b0) && n < 4000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 4000) chk("wait bound", 16'h0000, 16'h0001);
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic start_scan();
      @(posedge sys_clk) scan_start <= 1'b1;
      @(posedge sys_clk) scan_start <= 1'b0;
   endtask
   task automatic fw_go(input logic [3:0] ch, input logic t);
      @(posedge sys_clk);
      fw_chan <= ch;
      temp_sel <= t;
      fw_step <= 1'b1;
      @(posedge sys_clk) fw_step <= 1'b0;
      wait_done();
   endtask
   initial begin
      for (int n = 0; n < 16; n++) begin
         sample_time[8*n+:8] = 8'(n + 1);
         chan_switches[4*n+:4] = 4'(n) ^ 4'h5;
      end
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(negedge sys_clk);
      chk("busy at reset", 16'h0000, {15'h0000, busy});
      chk("flag at reset", 16'h0000, {15'h0000, range_irq});
      for (int r = 0; r < 4; r++) begin
         @(posedge sys_clk) ref_sel <= sarsq_ref_type'(r);
         repeat (2) @(negedge sys_clk);
         chk("reference", 16'(r), {14'h0000, ref_out});
      end
      expect_res(0, 'h05A, 0);
      expect_res(2, 'h25A, (3 + 18) * 8);
      expect_res(5, 'h55A, (6 + 18) * 8);
      start_scan();
      wait_done();
      chk("done count", 16'h0001, 16'(done_cnt));
      chk("range flag", 16'h0001, {15'h0000, range_irq});
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk) read_chan <= 4'(rc[i]);
         @(posedge sys_clk);
         @(negedge sys_clk);
         chk("held result", 16'({rc[i], 8'h5A}), {4'h0, read_data});
      end
      @(posedge sys_clk) range_irq_clear <= 1'b1;
      @(posedge sys_clk) range_irq_clear <= 1'b0;
      @(negedge sys_clk);
      chk("range clear", 16'h0000, {15'h0000, range_irq});
      // frozen clock enable: a start and a reference change must both be held off
      @(posedge sys_clk) clk_en <= 1'b0;
      ref_sel <= SARSQ_REF_SUPPLY;
      start_scan();
      @(negedge sys_clk);
      chk("frozen start", 16'h0000, {15'h0000, busy});
      chk("frozen reference", 16'h0003, {14'h0000, ref_out});
      @(posedge sys_clk) clk_en <= 1'b1;
      repeat (2) @(negedge sys_clk);
      chk("thawed reference", 16'h0000, {14'h0000, ref_out});
      @(posedge sys_clk);
      extend_16 <= 1'b1;
      chan_enable <= 16'h8001;
      limit_high <= 12'hFFF;
      continuous <= 1'b1;
      expect_res(0, 'h05A, 0);
      expect_res(15, 'hF5A, (16 + 18) * 8);
      expect_res(0, 'h05A, (1 + 18) * 8);
      expect_res(15, 'hF5A, (16 + 18) * 8);
      start_scan();
      // second pass is the last: continuous drops once the first wrap is reported
      wait (done_cnt == 2);
      @(posedge sys_clk) continuous <= 1'b0;
      wait_done();
      chk("done count", 16'h0003, 16'(done_cnt));
      chk("in range", 16'h0000, {15'h0000, range_irq});
      @(posedge sys_clk) fw_step_mode <= 1'b1;
      expect_res(3, 'h35A, 0);
      fw_go(4'h3, 1'b0);
      expect_res(-1, 'hABC, 0);
      fw_go(4'h3, 1'b1);
      chk("no done in firmware", 16'h0003, 16'(done_cnt));
      @(posedge sys_clk) fw_step_mode <= 1'b0;
      start_scan();
      repeat (20) @(posedge sys_clk);
      active_mode <= 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk("busy in sleep", 16'h0000, {15'h0000, busy});
      start_scan();
      repeat (400) @(posedge sys_clk);
      chk("refused start", 16'h0000, {15'h0000, busy});
      tally_and_finish();
   end
endmodule
